// ---- tb/srpm_ctrl_props.sv ----
/*
 Port checker for srpm_ctrl: register read-back, sleep entry, wake delay, reset hold.
 Assumes straps and the incompatible-peripheral pin only change with the scenario.
*/
module srpm_ctrl_props (
   // Clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // Register port
   input wire [7:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [7:0] o_rdata,
   // Sleep and straps
   input wire i_sleep_instr,
   input wire i_wake_event,
   input wire o_sleeping,
   input wire o_exec_resume,
   input wire i_incompat_periph_en,
   input wire i_unregulated_variant,
   input wire i_cap_charged,
   input wire i_cap_pin_select,
   // Regulator outputs
   input wire o_regulator_lowpower,
   input wire o_reference_lowpower,
   input wire o_regulator_enable,
   input wire o_core_rst,
   input wire o_regulator_cap_pin_pa5
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_lp_wake;
      o_sleeping && o_regulator_lowpower && i_wake_event;
   endsequence
   // Stabilisation window, 200 cycles nominal
   sequence s_stab;
      (!o_exec_resume && !o_sleeping) [*8] ##[185:195] o_exec_resume;
   endsequence
   AST_RD_FIXED: assert property (i_rd && i_addr == 8'h00 |=> o_rdata[7:2] == 6'h00 && o_rdata[0])
      else $error("fixed bits wrong");
   AST_WR_RD: assert property (i_wr && i_addr == 8'h00 && !i_unregulated_variant ##1 i_rd && i_addr == 8'h00
      |=> o_rdata[1] == $past(i_wdata[1], 2)) else $error("select bit lost");
   AST_REG_ON: assert property (o_regulator_enable) else $error("regulator off");
   AST_NORM_WAKE: assert property (o_sleeping && !o_regulator_lowpower && i_wake_event
      |=> o_exec_resume && !o_sleeping) else $error("normal wake delayed");
   AST_LP_WAKE: assert property (s_lp_wake |=> s_stab) else $error("wake delay wrong");
   AST_LP_PAIR: assert property ($rose(o_regulator_lowpower) |-> $rose(o_sleeping) && o_reference_lowpower)
      else $error("low power pairing");
   AST_ENTRY: assert property ($rose(o_sleeping) |-> $past(i_sleep_instr) && $past(o_exec_resume))
      else $error("sleep without instruction");
   AST_INCOMPAT: assert property (i_incompat_periph_en [*3] ##0 (o_exec_resume && i_sleep_instr)
      |=> !o_regulator_lowpower) else $error("low power with peripheral");
   AST_RST_HOLD: assert property (o_core_rst && !i_cap_charged |=> o_core_rst) else $error("early release");
   AST_CAP_PIN: assert property (!o_core_rst |-> o_regulator_cap_pin_pa5 == !i_cap_pin_select)
      else $error("cap pin decode");
endmodule
bind srpm_ctrl srpm_ctrl_props srpm_ctrl_props_i (.*);

// ---- tb/srpm_ctrl_tb.sv ----
/*
 Testbench for srpm_ctrl: register port, sleep modes, variant strap, power-up hold.
 Assumes the checker binds itself from its own file.
*/
module srpm_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, i_sleep_instr = 0, i_wake_event = 0;
   logic i_incompat_periph_en = 0, i_unregulated_variant = 0, i_cap_charged = 0, i_cap_pin_select = 0;
   logic i_brownout_reset_en = 0, i_watchdog_en = 0, i_pin_irq_en = 0, i_timer1_ext_en = 0, i_capture_unit_en = 0;
   logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, d;
   logic o_sleeping, o_exec_resume, o_regulator_lowpower, o_reference_lowpower;
   logic o_regulator_enable, o_core_rst, o_regulator_cap_pin_pa5, rd_pend = 0;
   int error_cnt = 0, checked = 0, seed = 56616, n;
   logic [7:0] exp_q[$];
   // Short charge count keeps power-up quick
   srpm_ctrl #(.CAP_CHARGE_CYC(4)) srpm_ctrl_i (.*);
   initial forever #5 i_clk = ~i_clk;
   task chk(input logic [7:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task complete_run;
      $display("checked %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Every call drives all strobes once, so back-to-back calls never double-assign
   task bus(input logic w, r, input logic [7:0] a, dt, e);
      i_wr <= w;
      i_rd <= r;
      i_addr <= a;
      i_wdata <= dt;
      if (r)
         exp_q.push_back(e);
      @(posedge i_clk);
   endtask
   always @(posedge i_clk) rd_pend <= i_rd;
   always @(negedge i_clk)
      if (rd_pend)
         chk(o_rdata, exp_q.pop_front());
   task rst(input logic v);
      i_unregulated_variant <= v;
      i_cap_pin_select <= v;
      i_cap_charged <= 0;
      i_sys_rst <= 1;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 0;
      repeat (12) @(posedge i_clk);
      chk(o_core_rst, 1);
      i_cap_charged <= 1;
      repeat (10) @(posedge i_clk);
      chk(o_core_rst, 0);
      chk(o_regulator_cap_pin_pa5, !v);
   endtask
   task slp(input logic lp, inc);
      i_incompat_periph_en <= inc;
      repeat (3) @(posedge i_clk);
      i_sleep_instr <= 1;
      @(posedge i_clk);
      i_sleep_instr <= 0;
      repeat (3) @(posedge i_clk);
      chk(o_reference_lowpower, lp);
      chk(o_regulator_lowpower, lp);
      i_wake_event <= 1;
      @(posedge i_clk);
      i_wake_event <= 0;
      n = 0;
      @(negedge i_clk);
      while (!o_exec_resume && n < 400)
      begin
         @(negedge i_clk);
         n++;
      end
      chk(8'(n), lp ? 8'd200 : 8'd0);
      @(posedge i_clk);
   endtask
   initial
   begin
      rst(0);
      bus(0, 1, 8'h00, 8'h00, 8'h01);
      bus(1, 0, 8'h00, 8'hff, 8'h00);
      bus(0, 1, 8'h00, 8'h00, 8'h03);
      bus(0, 1, 8'h5a, 8'h00, 8'h00);
      bus(1, 0, 8'h01, 8'h00, 8'h00);
      bus(0, 1, 8'h00, 8'h00, 8'h03);
      repeat (8)
      begin
         d = $random(seed);
         bus(1, 0, 8'h00, d | 8'h01, 8'h00);
         bus(0, 1, 8'h00, 8'h00, {6'h00, d[1], 1'b1});
      end
      bus(1, 0, 8'h00, 8'h03, 8'h00);
      bus(0, 0, 8'h00, 8'h00, 8'h00);
      $display("register tests done");
      {i_brownout_reset_en, i_watchdog_en, i_pin_irq_en, i_timer1_ext_en, i_capture_unit_en} <= 5'h1f;
      slp(1, 0);
      slp(0, 1);
      bus(1, 0, 8'h00, 8'h01, 8'h00);
      bus(0, 0, 8'h00, 8'h00, 8'h00);
      slp(0, 0);
      $display("sleep tests done");
      rst(1);
      bus(1, 0, 8'h00, 8'h03, 8'h00);
      bus(0, 1, 8'h00, 8'h00, 8'h01);
      bus(0, 0, 8'h00, 8'h00, 8'h00);
      slp(0, 0);
      $display("variant tests done");
      complete_run;
   end
   initial
   begin
      repeat (5000) @(posedge i_clk);
      error_cnt++;
      complete_run;
   end
endmodule

// ---- verilog/srpm_ctrl.v ----
/*
 Sleep regulator power-mode controller: control register, sleep mode
 selection, wake-up stabilisation delay, power-up capacitor-charge reset
 hold and capacitor pin decode.
 Assumes the core pulses sleep entry and wake events on i_clk, and that
 peripheral enables, charge-done and variant straps are pins.
*/
`include "srpm_defs.vh"

module srpm_ctrl #(
   parameter CAP_CHARGE_CYC = `SRPM_CAP_CHARGE_CYC
)
(
   // Clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // Register port
   input wire [`SRPM_ADDR_W-1:0] i_addr,
   input wire [7:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [7:0] o_rdata,
   // Core sleep handshake
   input wire i_sleep_instr,
   input wire i_wake_event,
   output wire o_sleeping,
   output wire o_exec_resume,
   // Peripherals enabled during sleep (pins)
   input wire i_incompat_periph_en,
   input wire i_brownout_reset_en,
   input wire i_watchdog_en,
   input wire i_pin_irq_en,
   input wire i_timer1_ext_en,
   input wire i_capture_unit_en,
   // Straps and analogue status (pins)
   input wire i_unregulated_variant,
   input wire i_cap_charged,
   input wire i_cap_pin_select,
   // Regulator and reset control
   output reg o_regulator_lowpower,
   output reg o_reference_lowpower,
   output wire o_regulator_enable,
   output reg o_core_rst,
   output wire o_regulator_cap_pin_pa5
);

   localparam [3:0] ST_RUN = 4'b0001;
   localparam [3:0] ST_SLEEP = 4'b0010;
   localparam [3:0] ST_STAB = 4'b0100;
   localparam [3:0] ST_PWRUP = 4'b1000;
   localparam [`SRPM_CNT_W-1:0] WAKE_CYC = `SRPM_WAKE_STAB_CYC;

   wire [4:0] periph_s;
   wire [2:0] strap_s;
   wire unreg_s;
   wire charged_s;
   wire capsel_s;
   wire lp_allowed;
   reg lp_sel_q;
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [`SRPM_CNT_W-1:0] stab_cnt_q;
   reg [31:0] chg_cnt_q;
   reg lp_sleep_q;
   wire lp_sleep_d;
   reg cap_pin_q;

   srpm_sync2 #(.W(5)) u_sync_periph (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_brownout_reset_en, i_watchdog_en, i_pin_irq_en, i_timer1_ext_en, i_capture_unit_en}),
      .o_sync(periph_s)
   );

   srpm_sync2 #(.W(3)) u_sync_strap (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async({i_unregulated_variant, i_cap_charged, i_cap_pin_select}),
      .o_sync(strap_s)
   );

   wire incompat_s;
   srpm_sync2 #(.W(1)) u_sync_incompat (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_incompat_periph_en),
      .o_sync(incompat_s)
   );

   assign unreg_s = strap_s[2];
   assign charged_s = strap_s[1];
   assign capsel_s = strap_s[0];

   // Listed peripherals never block low power; only incompatible ones do
   assign lp_allowed = ~incompat_s;

   // Mode taken at the entry edge so low-power outputs rise with sleep
   assign lp_sleep_d = (state_q == ST_RUN && i_sleep_instr) ? (lp_sel_q & lp_allowed & ~unreg_s) : lp_sleep_q;

   // Regulator has no off switch
   assign o_regulator_enable = 1'b1;

   // Control register
   always @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         lp_sel_q <= `SRPM_LP_SEL_RESET;
      end
      else if (i_wr && i_addr == `SRPM_REGCTL_OFFSET)
      begin
         lp_sel_q <= i_wdata[`SRPM_LP_SEL_BIT];
      end
   end

   always @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         o_rdata <= 8'h00;
      end
      else if (i_rd && i_addr == `SRPM_REGCTL_OFFSET)
      begin
         o_rdata <= 8'h00;
         o_rdata[`SRPM_LP_SEL_BIT] <= lp_sel_q & ~unreg_s;
         o_rdata[`SRPM_RSVD_BIT] <= `SRPM_RSVD_VALUE;
      end
      else
      begin
         o_rdata <= 8'h00;
      end
   end

   // Sequencer
   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_PWRUP:
         begin
            if (charged_s && chg_cnt_q == 32'h0000_0000)
            begin
               state_d = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (i_sleep_instr)
            begin
               state_d = ST_SLEEP;
            end
         end
         ST_SLEEP:
         begin
            if (i_wake_event)
            begin
               // Only a low-power sleep pays the delay
               state_d = lp_sleep_q ? ST_STAB : ST_RUN;
            end
         end
         ST_STAB:
         begin
            if (stab_cnt_q == {`SRPM_CNT_W{1'b0}})
            begin
               state_d = ST_RUN;
            end
         end
         default:
         begin
            state_d = ST_PWRUP;
         end
      endcase
   end

   always @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         state_q <= ST_PWRUP;
         stab_cnt_q <= {`SRPM_CNT_W{1'b0}};
         chg_cnt_q <= 32'h0000_0000;
         lp_sleep_q <= 1'b0;
         o_regulator_lowpower <= 1'b0;
         o_reference_lowpower <= 1'b0;
         o_core_rst <= 1'b1;
         cap_pin_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == ST_PWRUP)
         begin
            // Minimum charge time counted once charging is reported done
            if (!charged_s)
            begin
               chg_cnt_q <= CAP_CHARGE_CYC;
            end
            else if (chg_cnt_q != 32'h0000_0000)
            begin
               chg_cnt_q <= chg_cnt_q - 32'h0000_0001;
            end
            // Strap caught while reset is still held
            cap_pin_q <= capsel_s;
         end
         o_core_rst <= (state_d == ST_PWRUP);
         // Unregulated variant: no penalty, lowest power is intrinsic
         lp_sleep_q <= lp_sleep_d;
         if (state_q == ST_SLEEP && i_wake_event && lp_sleep_q)
         begin
            stab_cnt_q <= WAKE_CYC - {{(`SRPM_CNT_W-1){1'b0}}, 1'b1};
         end
         else if (state_q == ST_STAB && stab_cnt_q != {`SRPM_CNT_W{1'b0}})
         begin
            stab_cnt_q <= stab_cnt_q - {{(`SRPM_CNT_W-1){1'b0}}, 1'b1};
         end
         // Incompatible peripheral enabled mid-sleep forces normal power
         o_regulator_lowpower <= (state_d == ST_SLEEP) && lp_sleep_d && lp_allowed;
         o_reference_lowpower <= (state_d == ST_SLEEP) && lp_sleep_d && lp_allowed;
      end
   end

   assign o_sleeping = state_q[1];
   assign o_exec_resume = state_q[0];
   assign o_regulator_cap_pin_pa5 = (cap_pin_q == `SRPM_CAP_PIN_PA5);

endmodule

// ---- verilog/srpm_defs.vh ----
/*
 Constants for the sleep regulator power-mode controller: register offset,
 field positions, reset values and timing counts.
 Assumes a 100 MHz core clock and a plain register port with
 read data one cycle after the read strobe.
*/
`ifndef SRPM_DEFS_VH
`define SRPM_DEFS_VH

`define SRPM_ADDR_W 8
`define SRPM_REGCTL_OFFSET 8'h00
`define SRPM_LP_SEL_BIT 1
`define SRPM_RSVD_BIT 0
`define SRPM_LP_SEL_RESET 1'b0
`define SRPM_RSVD_VALUE 1'b1
`define SRPM_CAP_PIN_PA5 1'b0
// Wake-up stabilisation time, in ns, and derived cycles at 10 ns period
`define SRPM_WAKE_STAB_NS 2000
`define SRPM_CLK_PERIOD_NS 10
`define SRPM_WAKE_STAB_CYC ((`SRPM_WAKE_STAB_NS + `SRPM_CLK_PERIOD_NS - 1) / `SRPM_CLK_PERIOD_NS)
`define SRPM_CNT_W 16
// Capacitor charge time at power-up, in ns
`define SRPM_CAP_CHARGE_NS 100000
`define SRPM_CAP_CHARGE_CYC ((`SRPM_CAP_CHARGE_NS + `SRPM_CLK_PERIOD_NS - 1) / `SRPM_CLK_PERIOD_NS)

`endif

// ---- verilog/srpm_sync2.v ----
/*
 Two-flop synchroniser for a group of level inputs from outside the clock domain.
 Assumes the inputs are quasi-static levels.
*/
module srpm_sync2 #(
   parameter W = 1
)
(
   // Clock and reset
   input wire i_clk,
   input wire i_sys_rst,
   // Data
   input wire [W-1:0] i_async,
   output wire [W-1:0] o_sync
);

   reg [W-1:0] meta_q;
   reg [W-1:0] sync_q;

   always @(posedge i_clk or posedge i_sys_rst)
   begin
      if (i_sys_rst)
      begin
         meta_q <= {W{1'b0}};
         sync_q <= {W{1'b0}};
      end
      else
      begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule
